// ### logic/cvt_pkg.sv
// Shared constants and types of the camera video and trigger interface
package cvt_pkg;

  // ****************************************
  // Clock and counter sizes
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int CW = 20;

  // ****************************************
  // Timing figures in ns, and the serial baud rate
  // ****************************************
  localparam int T_A0_NS = 85;
  localparam int T_A1_NS = 186;
  localparam int T_A2_NS = 485000;
  localparam int T_B4_0_NS = 123;
  localparam int T_B4_1_NS = 486000;
  localparam int T_B4_2_NS = 247;
  localparam int T_B6_0_NS = 123;
  localparam int T_B6_1_NS = 286;
  localparam int T_B6_2_NS = 484000;
  localparam int T_C01_NS = 112;
  localparam int T_C2_NS = 1400;
  localparam int T_D_NS = 3110;
  localparam int T_E0_NS = 57000;
  localparam int T_E1_NS = 112000;
  localparam int T_E2_NS = 70200;
  localparam int T_E3_NS = 138000;
  localparam int T_DEBOUNCE_NS = 1070;
  localparam int BAUD_RATE = 9600;

  // ****************************************
  // Trigger modes and option codes
  // ****************************************
  localparam logic [2:0] MODE_INTERNAL = 3'h2;
  localparam logic [2:0] MODE_LEVEL = 3'h4;
  localparam logic [2:0] MODE_FALL = 3'h6;
  localparam logic [1:0] OPT_0 = 2'h0;
  localparam logic [1:0] OPT_1 = 2'h1;
  localparam logic [2:0] UART_DATA_BITS = 3'h7;
  localparam logic [7:0] UNUSED_FILL = 8'h00;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {RD_IDLE, RD_LINE, RD_GAP} cvt_rd_state_t;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} cvt_ser_state_t;

  // Least time in ns to whole clock cycles, at least one
  function automatic int cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc

endpackage : cvt_pkg

// ### logic/cvt_camera_video_trigger.sv
// Camera video output, control input, trigger timing and serial link logic
`timescale 1ns/1ps
module cvt_camera_video_trigger #(
  parameter int PixelBits = 8,
  parameter int DataWidth = 24,
  parameter int PixelsPerLine = 16,
  parameter int LinesPerFrame = 8,
  parameter int LineGapCyc = 4,
  parameter int ExposureCyc = 200,
  parameter int PeriodCyc = 4000,
  parameter int DlyA2Cyc = cvt_pkg::cyc(cvt_pkg::T_A2_NS),
  parameter int DlyB41Cyc = cvt_pkg::cyc(cvt_pkg::T_B4_1_NS),
  parameter int DlyB62Cyc = cvt_pkg::cyc(cvt_pkg::T_B6_2_NS),
  parameter int DlyE0Cyc = cvt_pkg::cyc(cvt_pkg::T_E0_NS),
  parameter int DlyE1Cyc = cvt_pkg::cyc(cvt_pkg::T_E1_NS),
  parameter int DlyE2Cyc = cvt_pkg::cyc(cvt_pkg::T_E2_NS),
  parameter int DlyE3Cyc = cvt_pkg::cyc(cvt_pkg::T_E3_NS),
  parameter int BaudDiv = cvt_pkg::CLK_MHZ * 1000000 / cvt_pkg::BAUD_RATE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control pairs from the frame grabber
  input wire logic extTrigger,
  input wire logic ccReserved2,
  input wire logic ccReserved3,
  input wire logic windowToggle,
  // Static configuration
  input wire logic [2:0] triggerMode,
  input wire logic [1:0] trigger_delay_option,
  input wire logic debounceEnable,
  input wire logic [1:0] speedConfig,
  // Video enables and data
  output logic frameValid,
  output logic lineValid,
  output logic dataValid,
  output logic spareEnable,
  output logic [DataWidth-1:0] videoData,
  // Internal timing state
  output logic internalTrigger,
  output logic exposure,
  output logic windowSelect,
  // Serial command link
  input wire logic serToCamera,
  output logic serToGrabber,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFrameError,
  input wire logic [7:0] txData,
  input wire logic txStart,
  output logic txBusy
);

  localparam int CW = cvt_pkg::CW;
  localparam logic [CW-1:0] ONE = CW'(1);

  // Pick one of three delays by option, adding debounce time if enabled
  function automatic logic [CW-1:0] pick(input logic [1:0] opt, input int d0, input int d1,
                                         input int d2, input logic deb);
    int d;
    d = (opt == cvt_pkg::OPT_0) ? d0 : (opt == cvt_pkg::OPT_1) ? d1 : d2;
    if (deb) d = d + cvt_pkg::cyc(cvt_pkg::T_DEBOUNCE_NS);
    return CW'(d);
  endfunction : pick

  // ****************************************
  // Trigger synchroniser and internal trigger
  // ****************************************
  logic trigMeta, trigSync, trigPrev;
  logic [CW-1:0] riseCnt, fallCnt, periodCnt;
  logic next_intTrig, next_windowSelect;
  logic [CW-1:0] next_riseCnt, next_fallCnt, next_periodCnt;
  logic extRise, extFall;

  assign extRise = trigSync & ~trigPrev;
  assign extFall = ~trigSync & trigPrev;

  always_comb begin
    next_intTrig = internalTrigger;
    next_riseCnt = (riseCnt != '0) ? riseCnt - ONE : riseCnt;
    next_fallCnt = (fallCnt != '0) ? fallCnt - ONE : fallCnt;
    next_periodCnt = periodCnt;
    next_windowSelect = windowToggle;
    if (riseCnt == ONE) next_intTrig = 1'b1;
    if (fallCnt == ONE) next_intTrig = 1'b0;
    case (triggerMode)
      cvt_pkg::MODE_INTERNAL: begin
        next_riseCnt = '0;
        if (periodCnt == '0) begin
          next_periodCnt = CW'(PeriodCyc - 1);
          next_intTrig = 1'b1;
          next_fallCnt = CW'(ExposureCyc);
        end else begin
          next_periodCnt = periodCnt - ONE;
        end
      end
      cvt_pkg::MODE_LEVEL: begin
        if (extRise) next_riseCnt = pick(trigger_delay_option, cvt_pkg::cyc(cvt_pkg::T_A0_NS),
            cvt_pkg::cyc(cvt_pkg::T_A1_NS), DlyA2Cyc, debounceEnable);
        if (extFall) next_fallCnt = pick(trigger_delay_option, cvt_pkg::cyc(cvt_pkg::T_B4_0_NS),
            DlyB41Cyc, cvt_pkg::cyc(cvt_pkg::T_B4_2_NS), debounceEnable);
      end
      cvt_pkg::MODE_FALL: begin
        if (extFall) next_riseCnt = pick(trigger_delay_option, cvt_pkg::cyc(cvt_pkg::T_B6_0_NS),
            cvt_pkg::cyc(cvt_pkg::T_B6_1_NS), DlyB62Cyc, debounceEnable);
        if (riseCnt == ONE) next_fallCnt = CW'(ExposureCyc);
      end
      default: begin
        next_riseCnt = '0;
        next_fallCnt = '0;
        next_intTrig = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    trigMeta <= extTrigger;
    trigSync <= trigMeta;
    if (reset) begin
      trigPrev <= 1'b0;
      internalTrigger <= 1'b0;
      riseCnt <= '0;
      fallCnt <= '0;
      periodCnt <= '0;
      windowSelect <= 1'b0;
    end else begin
      trigPrev <= trigSync;
      internalTrigger <= next_intTrig;
      riseCnt <= next_riseCnt;
      fallCnt <= next_fallCnt;
      periodCnt <= next_periodCnt;
      windowSelect <= next_windowSelect;
    end
  end

  // ****************************************
  // Exposure window
  // ****************************************
  logic trigSeen, next_exposure;
  logic [CW-1:0] expRiseCnt, expFallCnt, next_expRiseCnt, next_expFallCnt;

  always_comb begin
    next_exposure = exposure;
    next_expRiseCnt = (expRiseCnt != '0) ? expRiseCnt - ONE : expRiseCnt;
    next_expFallCnt = (expFallCnt != '0) ? expFallCnt - ONE : expFallCnt;
    if (expRiseCnt == ONE) next_exposure = 1'b1;
    if (expFallCnt == ONE) next_exposure = 1'b0;
    if (internalTrigger && !trigSeen) next_expRiseCnt = pick(trigger_delay_option,
        cvt_pkg::cyc(cvt_pkg::T_C01_NS), cvt_pkg::cyc(cvt_pkg::T_C01_NS),
        cvt_pkg::cyc(cvt_pkg::T_C2_NS), 1'b0);
    if (!internalTrigger && trigSeen) next_expFallCnt = CW'(cvt_pkg::cyc(cvt_pkg::T_D_NS));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trigSeen <= 1'b0;
      exposure <= 1'b0;
      expRiseCnt <= '0;
      expFallCnt <= '0;
    end else begin
      trigSeen <= internalTrigger;
      exposure <= next_exposure;
      expRiseCnt <= next_expRiseCnt;
      expFallCnt <= next_expFallCnt;
    end
  end

  // ****************************************
  // Frame readout
  // ****************************************
  cvt_pkg::cvt_rd_state_t rdState, next_rdState;
  logic [CW-1:0] startCnt, next_startCnt, pixCnt, next_pixCnt, lineCnt, next_lineCnt;
  logic next_fval, next_lval, next_dval;
  logic [DataWidth-1:0] next_videoData;

  always_comb begin
    next_rdState = rdState;
    next_startCnt = (startCnt != '0) ? startCnt - ONE : startCnt;
    next_pixCnt = pixCnt;
    next_lineCnt = lineCnt;
    next_fval = frameValid;
    next_lval = lineValid;
    next_dval = dataValid;
    if (expFallCnt == ONE) begin
      case (speedConfig)
        2'h0: next_startCnt = CW'(DlyE0Cyc);
        2'h1: next_startCnt = CW'(DlyE1Cyc);
        2'h2: next_startCnt = CW'(DlyE2Cyc);
        default: next_startCnt = CW'(DlyE3Cyc);
      endcase
    end
    case (rdState)
      cvt_pkg::RD_IDLE: begin
        if (startCnt == ONE) begin
          next_rdState = cvt_pkg::RD_LINE;
          next_fval = 1'b1;
          next_lval = 1'b1;
          next_dval = 1'b1;
          next_pixCnt = '0;
          next_lineCnt = '0;
        end
      end
      cvt_pkg::RD_LINE: begin
        next_pixCnt = pixCnt + ONE;
        if (pixCnt == CW'(PixelsPerLine - 1)) begin
          next_lval = 1'b0;
          next_dval = 1'b0;
          next_pixCnt = '0;
          if (lineCnt == CW'(LinesPerFrame - 1)) begin
            next_fval = 1'b0;
            next_rdState = cvt_pkg::RD_IDLE;
          end else begin
            next_rdState = cvt_pkg::RD_GAP;
          end
        end
      end
      cvt_pkg::RD_GAP: begin
        next_pixCnt = pixCnt + ONE;
        if (pixCnt == CW'(LineGapCyc - 1)) begin
          next_pixCnt = '0;
          next_lineCnt = lineCnt + ONE;
          next_lval = 1'b1;
          next_dval = 1'b1;
          next_rdState = cvt_pkg::RD_LINE;
        end
      end
      default: begin
        next_rdState = cvt_pkg::RD_IDLE;
        next_fval = 1'b0;
        next_lval = 1'b0;
        next_dval = 1'b0;
      end
    endcase
    next_videoData = {DataWidth{cvt_pkg::UNUSED_FILL[0]}};
    if (next_dval) next_videoData[PixelBits-1:0] = PixelBits'(next_pixCnt + next_lineCnt);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdState <= cvt_pkg::RD_IDLE;
      startCnt <= '0;
      pixCnt <= '0;
      lineCnt <= '0;
      frameValid <= 1'b0;
      lineValid <= 1'b0;
      dataValid <= 1'b0;
      spareEnable <= 1'b0;
      videoData <= '0;
    end else begin
      rdState <= next_rdState;
      startCnt <= next_startCnt;
      pixCnt <= next_pixCnt;
      lineCnt <= next_lineCnt;
      frameValid <= next_fval;
      lineValid <= next_lval;
      dataValid <= next_dval;
      spareEnable <= cvt_pkg::UNUSED_FILL[0];
      videoData <= next_videoData;
    end
  end

  // ****************************************
  // Serial receiver
  // ****************************************
  cvt_pkg::cvt_ser_state_t rxState, next_rxState;
  logic [CW-1:0] rxCnt, next_rxCnt;
  logic [2:0] rxBit, next_rxBit;
  logic [7:0] rxShift, next_rxShift, next_rxData;
  logic next_rxValid, next_rxFrameError;

  always_comb begin
    next_rxState = rxState;
    next_rxCnt = (rxCnt != '0) ? rxCnt - ONE : rxCnt;
    next_rxBit = rxBit;
    next_rxShift = rxShift;
    next_rxData = rxData;
    next_rxValid = 1'b0;
    next_rxFrameError = 1'b0;
    case (rxState)
      cvt_pkg::SER_IDLE: begin
        if (!serToCamera) begin
          next_rxState = cvt_pkg::SER_START;
          next_rxCnt = CW'(BaudDiv / 2);
        end
      end
      cvt_pkg::SER_START: begin
        if (rxCnt == '0) begin
          next_rxState = serToCamera ? cvt_pkg::SER_IDLE : cvt_pkg::SER_DATA;
          next_rxCnt = CW'(BaudDiv - 1);
          next_rxBit = '0;
        end
      end
      cvt_pkg::SER_DATA: begin
        if (rxCnt == '0) begin
          next_rxShift = {serToCamera, rxShift[7:1]};
          next_rxCnt = CW'(BaudDiv - 1);
          next_rxBit = rxBit + 3'h1;
          if (rxBit == cvt_pkg::UART_DATA_BITS) next_rxState = cvt_pkg::SER_STOP;
        end
      end
      cvt_pkg::SER_STOP: begin
        if (rxCnt == '0) begin
          next_rxState = cvt_pkg::SER_IDLE;
          next_rxValid = serToCamera;
          next_rxFrameError = !serToCamera;
          if (serToCamera) next_rxData = rxShift;
        end
      end
      default: next_rxState = cvt_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxState <= cvt_pkg::SER_IDLE;
      rxCnt <= '0;
      rxBit <= '0;
      rxShift <= '0;
      rxData <= '0;
      rxValid <= 1'b0;
      rxFrameError <= 1'b0;
    end else begin
      rxState <= next_rxState;
      rxCnt <= next_rxCnt;
      rxBit <= next_rxBit;
      rxShift <= next_rxShift;
      rxData <= next_rxData;
      rxValid <= next_rxValid;
      rxFrameError <= next_rxFrameError;
    end
  end

  // ****************************************
  // Serial transmitter
  // ****************************************
  cvt_pkg::cvt_ser_state_t txState, next_txState;
  logic [CW-1:0] txCnt, next_txCnt;
  logic [2:0] txBit, next_txBit;
  logic [7:0] txShift, next_txShift;
  logic next_serOut, next_txBusy;

  always_comb begin
    next_txState = txState;
    next_txCnt = (txCnt != '0) ? txCnt - ONE : txCnt;
    next_txBit = txBit;
    next_txShift = txShift;
    next_serOut = serToGrabber;
    next_txBusy = txBusy;
    case (txState)
      cvt_pkg::SER_IDLE: begin
        next_serOut = 1'b1;
        if (txStart) begin
          next_txState = cvt_pkg::SER_START;
          next_txShift = txData;
          next_serOut = 1'b0;
          next_txBusy = 1'b1;
          next_txCnt = CW'(BaudDiv - 1);
        end
      end
      cvt_pkg::SER_START: begin
        if (txCnt == '0) begin
          next_txState = cvt_pkg::SER_DATA;
          next_serOut = txShift[0];
          next_txShift = {1'b0, txShift[7:1]};
          next_txBit = '0;
          next_txCnt = CW'(BaudDiv - 1);
        end
      end
      cvt_pkg::SER_DATA: begin
        if (txCnt == '0) begin
          next_txCnt = CW'(BaudDiv - 1);
          next_txBit = txBit + 3'h1;
          next_serOut = txShift[0];
          next_txShift = {1'b0, txShift[7:1]};
          if (txBit == cvt_pkg::UART_DATA_BITS) begin
            next_serOut = 1'b1;
            next_txState = cvt_pkg::SER_STOP;
          end
        end
      end
      cvt_pkg::SER_STOP: begin
        if (txCnt == '0) begin
          next_txState = cvt_pkg::SER_IDLE;
          next_txBusy = 1'b0;
        end
      end
      default: next_txState = cvt_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txState <= cvt_pkg::SER_IDLE;
      txCnt <= '0;
      txBit <= '0;
      txShift <= '0;
      serToGrabber <= 1'b1;
      txBusy <= 1'b0;
    end else begin
      txState <= next_txState;
      txCnt <= next_txCnt;
      txBit <= next_txBit;
      txShift <= next_txShift;
      serToGrabber <= next_serOut;
      txBusy <= next_txBusy;
    end
  end

endmodule : cvt_camera_video_trigger

// ### testbench/cvt_trigger_props.sv
// Checker of the video enables, trigger timing and serial output
`timescale 1ns/1ps
module cvt_trigger_checker #(
  parameter int DataWidth = 24,
  parameter int PixelBits = 8,
  parameter int PixelsPerLine = 16,
  parameter int DlyE0Cyc = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Video side
  input wire logic frameValid,
  input wire logic lineValid,
  input wire logic dataValid,
  input wire logic spareEnable,
  input wire logic [DataWidth-1:0] videoData,
  // Timing side
  input wire logic internalTrigger,
  input wire logic exposure,
  input wire logic windowToggle,
  input wire logic windowSelect,
  input wire logic [1:0] trigger_delay_option,
  input wire logic [1:0] speedConfig,
  // Serial side
  input wire logic txStart,
  input wire logic txBusy,
  input wire logic serToGrabber
);
  localparam int ELo = DlyE0Cyc - 1;
  localparam int EHi = DlyE0Cyc + 2;
  int runLen;
  int next_runLen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Length of the current line enable run
  always_comb begin
    next_runLen = lineValid ? runLen + 1 : 0;
  end
  always_ff @(posedge clk) begin
    runLen <= reset ? 0 : next_runLen;
  end
  spare_zero_a: assert property (spareEnable == 1'h0)
    else $error("spare enable not low");
  unused_bits_a: assert property (videoData[DataWidth-1:PixelBits] == '0)
    else $error("unused video bits not fixed");
  line_in_frame_a: assert property (lineValid |-> frameValid)
    else $error("line enable outside frame");
  data_in_line_a: assert property (dataValid |-> lineValid)
    else $error("data enable outside line");
  line_length_a: assert property ($fell(lineValid) |-> runLen == PixelsPerLine)
    else $error("line length wrong");
  window_copy_a: assert property ($changed(windowToggle) |=> windowSelect == $past(windowToggle))
    else $error("window select not following");
  expo_start_a: assert property
    ($rose(internalTrigger) && trigger_delay_option != 2'h2 |-> ##[11:13] $rose(exposure))
    else $error("short exposure start delay wrong");
  expo_slow_a: assert property
    ($rose(internalTrigger) && trigger_delay_option == 2'h2 |-> ##[139:141] $rose(exposure))
    else $error("long exposure start delay wrong");
  expo_end_a: assert property ($fell(internalTrigger) |-> ##[310:312] $fell(exposure))
    else $error("exposure end delay wrong");
  frame_start_a: assert property
    ($fell(exposure) && !frameValid && speedConfig == 2'h0 |-> ##[ELo:EHi] $rose(frameValid))
    else $error("frame start delay wrong");
  tx_start_a: assert property (txStart && !txBusy |=> !serToGrabber && txBusy)
    else $error("start bit not sent");
  ser_idle_a: assert property (!txBusy |-> serToGrabber)
    else $error("serial out not idle high");
endmodule : cvt_trigger_checker

bind cvt_camera_video_trigger cvt_trigger_checker #(.DataWidth(DataWidth),
  .PixelBits(PixelBits), .PixelsPerLine(PixelsPerLine), .DlyE0Cyc(DlyE0Cyc)) u_chk (
  .clk, .reset, .frameValid, .lineValid, .dataValid, .spareEnable, .videoData,
  .internalTrigger, .exposure, .windowToggle, .windowSelect, .trigger_delay_option,
  .speedConfig, .txStart, .txBusy, .serToGrabber);

// ### testbench/cvt_grabber_model.sv
// Frame grabber model driving control pairs and the serial link
`timescale 1ns/1ps
module cvt_grabber_model #(
  parameter int BaudDiv = 16
) (
  // Clock
  input wire logic clk,
  // Control pairs
  output logic extTrigger,
  output logic ccReserved2,
  output logic ccReserved3,
  output logic windowToggle,
  // Serial link
  output logic serToCamera,
  input wire logic serToGrabber
);
  initial begin
    extTrigger = 1'h0;
    ccReserved2 = 1'h0;
    ccReserved3 = 1'h1;
    windowToggle = 1'h0;
    serToCamera = 1'h1;
  end
  // Reserved pairs carry noise that the camera must ignore
  always @(posedge clk) begin
    ccReserved2 <= ~ccReserved2;
    ccReserved3 <= ccReserved2;
  end
  task automatic trigPulse(input int hi);
    @(posedge clk);
    extTrigger <= 1'h1;
    repeat (hi) @(posedge clk);
    extTrigger <= 1'h0;
  endtask : trigPulse
  task automatic setWindow(input logic v);
    @(posedge clk);
    windowToggle <= v;
  endtask : setWindow
  // Start bit, eight bits from the lowest, stop bit, no parity
  task automatic sendByte(input logic [7:0] d, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      serToCamera <= f[i];
      repeat (BaudDiv - 1) @(posedge clk);
    end
    @(posedge clk);
    serToCamera <= 1'h1;
  endtask : sendByte
  task automatic recvByte(output logic [7:0] d, output logic stopBit);
    int n;
    n = 0;
    while (serToGrabber !== 1'h0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (BaudDiv / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BaudDiv) @(negedge clk);
      d[i] = serToGrabber;
    end
    repeat (BaudDiv) @(negedge clk);
    stopBit = serToGrabber;
  endtask : recvByte
endmodule : cvt_grabber_model

// ### testbench/cvt_camera_video_trigger_tb.sv
// Self-checking testbench of the camera video and trigger block
`timescale 1ns/1ps
module cvt_camera_video_trigger_tb;
  typedef struct {
    logic [2:0] mode;
    logic [1:0] opt;
    logic deb;
    logic [1:0] spd;
    int rise;
    int fall;
    int expo;
    int e;
  } cvt_row_t;
  localparam int Expo = 200;
  localparam int Period = 500;
  localparam int Baud = 16;
  localparam int Ppl = 16;
  localparam int Lpf = 8;
  localparam int E0 = 50, E1 = 60, E2 = 70, E3 = 80, A2 = 60, B41 = 70, B62 = 80;
  logic clk, reset, extTrigger, ccReserved2, ccReserved3, windowToggle, debounceEnable;
  logic [2:0] triggerMode;
  logic [1:0] trigger_delay_option, speedConfig, rxSeen;
  logic frameValid, lineValid, dataValid, spareEnable, internalTrigger, exposure;
  logic windowSelect, serToCamera, serToGrabber, rxValid, rxFrameError, txStart, txBusy;
  logic [23:0] videoData;
  logic [7:0] rxData, txData, rxByte;
  logic rxStop;
  int nMismatch, testsRun, tr, tf, er, ef, fr, tr2, nLine, nData, nLow;
  cvt_row_t rows [7];

  cvt_camera_video_trigger #(.PeriodCyc(Period), .DlyA2Cyc(A2), .DlyB41Cyc(B41),
    .DlyB62Cyc(B62), .DlyE0Cyc(E0), .DlyE1Cyc(E1), .DlyE2Cyc(E2), .DlyE3Cyc(E3),
    .BaudDiv(Baud)) u_cvt_camera_video_trigger (
    .clk(clk), .reset(reset), .extTrigger(extTrigger), .ccReserved2(ccReserved2),
    .ccReserved3(ccReserved3), .windowToggle(windowToggle), .triggerMode(triggerMode),
    .trigger_delay_option(trigger_delay_option), .debounceEnable(debounceEnable),
    .speedConfig(speedConfig), .frameValid(frameValid), .lineValid(lineValid),
    .dataValid(dataValid), .spareEnable(spareEnable), .videoData(videoData),
    .internalTrigger(internalTrigger), .exposure(exposure), .windowSelect(windowSelect),
    .serToCamera(serToCamera), .serToGrabber(serToGrabber), .rxData(rxData),
    .rxValid(rxValid), .rxFrameError(rxFrameError), .txData(txData), .txStart(txStart),
    .txBusy(txBusy));
  cvt_grabber_model #(.BaudDiv(Baud)) grab (.clk(clk), .extTrigger(extTrigger),
    .ccReserved2(ccReserved2), .ccReserved3(ccReserved3), .windowToggle(windowToggle),
    .serToCamera(serToCamera), .serToGrabber(serToGrabber));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ****
  // Compare and helper tasks
  // ****
  task automatic checkRange(input string what, input int got, input int lo, input int hi);
    testsRun++;
    if (got < lo || got > hi) begin
      nMismatch++;
      $display("Error at %0t: %s got %0d, expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : checkRange
  task automatic checkVal(input string what, input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: %s got %h, expected %h", $time, what, got, exp);
    end
  endtask : checkVal
  task automatic checkIdle();
    checkVal("idle outputs", {internalTrigger, exposure, frameValid, lineValid, dataValid,
      spareEnable, txBusy, serToGrabber}, 8'h01);
  endtask : checkIdle
  task automatic measure(input int hi);
    logic pT, pE, pF, pL;
    tr = -1;
    tf = -1;
    er = -1;
    ef = -1;
    fr = -1;
    tr2 = -1;
    nLine = 0;
    nData = 0;
    pT = internalTrigger;
    pE = exposure;
    pF = frameValid;
    pL = lineValid;
    fork
      grab.trigPulse(hi);
      for (int i = 1; i <= 1100; i++) begin
        @(posedge clk);
        #1;
        if (internalTrigger && !pT && tr >= 0 && tr2 < 0) tr2 = i;
        if (internalTrigger && !pT && tr < 0) tr = i;
        if (!internalTrigger && pT && tf < 0) tf = i;
        if (exposure && !pE && er < 0) er = i;
        if (!exposure && pE && ef < 0) ef = i;
        if (frameValid && !pF && fr < 0) fr = i;
        if (lineValid && !pL) nLine++;
        if (dataValid === 1'h1) nData++;
        pT = internalTrigger;
        pE = exposure;
        pF = frameValid;
        pL = lineValid;
      end
    join
  endtask : measure
  task automatic waitRx();
    rxSeen = 2'h0;
    for (int i = 0; i < 400 && rxSeen == 2'h0; i++) begin
      @(posedge clk);
      #1;
      rxSeen = {rxValid === 1'h1, rxFrameError === 1'h1};
    end
  endtask : waitRx
  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    repeat (40000) @(posedge clk);
    nMismatch++;
    $display("Error at %0t: watchdog expired", $time);
    tallyAndFinish();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    nMismatch = 0;
    testsRun = 0;
    reset = 1'h1;
    triggerMode = 3'h0;
    trigger_delay_option = 2'h0;
    debounceEnable = 1'h0;
    speedConfig = 2'h0;
    txData = 8'h00;
    txStart = 1'h0;
    rows[0] = '{cvt_pkg::MODE_LEVEL, 2'h0, 1'h0, 2'h0, 9, 13, 12, E0};
    rows[1] = '{cvt_pkg::MODE_LEVEL, 2'h1, 1'h0, 2'h1, 19, B41, 12, E1};
    rows[2] = '{cvt_pkg::MODE_LEVEL, 2'h2, 1'h0, 2'h2, A2, 25, 140, E2};
    rows[3] = '{cvt_pkg::MODE_LEVEL, 2'h0, 1'h1, 2'h3, 116, 120, 12, E3};
    rows[4] = '{cvt_pkg::MODE_FALL, 2'h0, 1'h0, 2'h0, 13, 0, 12, E0};
    rows[5] = '{cvt_pkg::MODE_FALL, 2'h1, 1'h0, 2'h1, 29, 0, 12, E1};
    rows[6] = '{cvt_pkg::MODE_FALL, 2'h2, 1'h0, 2'h2, B62, 0, 140, E2};
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1;
    checkIdle();
    foreach (rows[k]) begin
      @(posedge clk);
      triggerMode <= rows[k].mode;
      trigger_delay_option <= rows[k].opt;
      debounceEnable <= rows[k].deb;
      speedConfig <= rows[k].spd;
      measure(150);
      if (rows[k].mode == cvt_pkg::MODE_FALL) begin
        checkRange("rise after fall", tr - 151, rows[k].rise, rows[k].rise + 6);
        checkRange("trigger width", tf - tr, Expo - 1, Expo + 1);
      end else begin
        checkRange("rise after rise", tr - 1, rows[k].rise, rows[k].rise + 6);
        checkRange("fall after fall", tf - 151, rows[k].fall, rows[k].fall + 6);
      end
      checkRange("exposure start", er - tr, rows[k].expo - 1, rows[k].expo + 1);
      checkRange("exposure end", ef - tf, 310, 312);
      checkRange("frame start", fr - ef, rows[k].e - 1, rows[k].e + 2);
      checkRange("readout after pin fall", fr, 152, 1100);
      checkRange("lines", nLine, Lpf, Lpf);
      checkRange("data words", nData, Lpf * Ppl, Lpf * Ppl);
      checkVal("frame end", {7'h0, frameValid}, 8'h00);
    end
    // ****
    // Awkward cases
    // ****
    @(posedge clk);
    triggerMode <= cvt_pkg::MODE_INTERNAL;
    speedConfig <= 2'h0;
    trigger_delay_option <= 2'h0;
    debounceEnable <= 1'h0;
    measure(150);
    checkRange("internal period", tr2 - tr, Period, Period);
    checkRange("internal width", tf - tr, Expo, Expo);
    grab.setWindow(1'h1);
    repeat (2) @(posedge clk);
    #1;
    checkVal("window select", {7'h0, windowSelect}, 8'h01);
    grab.setWindow(1'h0);
    repeat (2) @(posedge clk);
    #1;
    checkVal("window select", {7'h0, windowSelect}, 8'h00);
    @(posedge clk);
    reset <= 1'h1;
    triggerMode <= 3'h0;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1;
    checkIdle();
    fork
      grab.sendByte(8'ha5, 1'h1);
      waitRx();
    join
    checkVal("rx outcome", {6'h0, rxSeen}, 8'h02);
    checkVal("rx data", rxData, 8'ha5);
    fork
      grab.sendByte(8'h5a, 1'h0);
      waitRx();
    join
    checkVal("rx stop error", {6'h0, rxSeen}, 8'h01);
    repeat (40 * Baud) @(posedge clk);
    fork
      grab.recvByte(rxByte, rxStop);
      begin
        txData <= 8'h3c;
        txStart <= 1'h1;
        @(posedge clk);
        txStart <= 1'h0;
        repeat (3) @(posedge clk);
        txData <= 8'hff;
        txStart <= 1'h1;
        @(posedge clk);
        txStart <= 1'h0;
      end
    join
    checkVal("tx data", rxByte, 8'h3c);
    checkVal("tx stop", {7'h0, rxStop}, 8'h01);
    nLow = 0;
    repeat (3 * Baud) begin
      @(posedge clk);
      #1;
      if (serToGrabber !== 1'h1) nLow++;
    end
    checkRange("no second character", nLow, 0, 0);
    tallyAndFinish();
  end
endmodule : cvt_camera_video_trigger_tb
